/* design/lctg_defines.svh */
`ifndef LCTG_DEFINES_SVH
`define LCTG_DEFINES_SVH

// Reference clock and link clock (link clock is reference divided by two)
`define LCTG_REF_PS 40000
`define LCTG_TCK_PS (2 * `LCTG_REF_PS)

// Larger of a time rounded up to link cycles and a cycle count
`define LCTG_CYC(ps, n) \
  ((((ps) + `LCTG_TCK_PS - 1) / `LCTG_TCK_PS) > (n) ? \
   (((ps) + `LCTG_TCK_PS - 1) / `LCTG_TCK_PS) : (n))

// Write strobe framing, in half link cycles (one reference cycle each), except write latency in link cycles
`define LCTG_WL_NCK 6
`define LCTG_DQSS_HALF 2
`define LCTG_PRE_HALF 4
`define LCTG_BURST_HALF 16
`define LCTG_PST_SHORT_HALF 1
`define LCTG_PST_LONG_HALF 3
`define LCTG_LATCH_HALF (1 + 2 * `LCTG_WL_NCK + `LCTG_DQSS_HALF)
`define LCTG_PRE_START_HALF (`LCTG_LATCH_HALF - `LCTG_PRE_HALF)
`define LCTG_BURST_END_HALF (`LCTG_LATCH_HALF + `LCTG_BURST_HALF)
`define LCTG_BURST_LAST_HALF (`LCTG_BURST_END_HALF - 1)

// Times in ps with their cycle minimums
`define LCTG_ZQLAT_PS 30000
`define LCTG_ZQLAT_NCK 8
`define LCTG_ZQRESET_PS 50000
`define LCTG_ZQRESET_NCK 3
`define LCTG_CKE_PS 7500
`define LCTG_CKE_NCK 4
`define LCTG_CMDCKE_PS 1750
`define LCTG_CMDCKE_NCK 3
`define LCTG_CKELCK_PS 5000
`define LCTG_CKELCK_NCK 5
`define LCTG_CKELCS_PS 5000
`define LCTG_CKELCS_NCK 5
`define LCTG_CKCKEH_PS 1750
`define LCTG_CKCKEH_NCK 3
`define LCTG_XP_PS 7500
`define LCTG_XP_NCK 5
`define LCTG_MRWCKEL_PS 14000
`define LCTG_MRWCKEL_NCK 10
`define LCTG_ZQCKE_PS 1750
`define LCTG_ZQCKE_NCK 3
`define LCTG_RCD_PS 18000
`define LCTG_RCD_NCK 4
`define LCTG_MRRI_EXTRA_NCK 3
`define LCTG_MRR_NCK 8
`define LCTG_MRW_PS 10000
`define LCTG_MRW_NCK 10
`define LCTG_MRD_PS 14000
`define LCTG_MRD_NCK 10

// Derived link cycle counts
`define LCTG_ZQLAT_CYC `LCTG_CYC(`LCTG_ZQLAT_PS, `LCTG_ZQLAT_NCK)
`define LCTG_ZQRESET_CYC `LCTG_CYC(`LCTG_ZQRESET_PS, `LCTG_ZQRESET_NCK)
`define LCTG_CKE_CYC `LCTG_CYC(`LCTG_CKE_PS, `LCTG_CKE_NCK)
`define LCTG_CMDCKE_CYC `LCTG_CYC(`LCTG_CMDCKE_PS, `LCTG_CMDCKE_NCK)
`define LCTG_CKELCK_CYC `LCTG_CYC(`LCTG_CKELCK_PS, `LCTG_CKELCK_NCK)
`define LCTG_CKELCS_CYC `LCTG_CYC(`LCTG_CKELCS_PS, `LCTG_CKELCS_NCK)
`define LCTG_CKCKEH_CYC `LCTG_CYC(`LCTG_CKCKEH_PS, `LCTG_CKCKEH_NCK)
`define LCTG_XP_CYC `LCTG_CYC(`LCTG_XP_PS, `LCTG_XP_NCK)
`define LCTG_MRWCKEL_CYC `LCTG_CYC(`LCTG_MRWCKEL_PS, `LCTG_MRWCKEL_NCK)
`define LCTG_ZQCKE_CYC `LCTG_CYC(`LCTG_ZQCKE_PS, `LCTG_ZQCKE_NCK)
`define LCTG_RCD_CYC `LCTG_CYC(`LCTG_RCD_PS, `LCTG_RCD_NCK)
`define LCTG_MRRI_CYC (`LCTG_XP_CYC + `LCTG_RCD_CYC + `LCTG_MRRI_EXTRA_NCK)
`define LCTG_MRW_CYC `LCTG_CYC(`LCTG_MRW_PS, `LCTG_MRW_NCK)
`define LCTG_MRD_CYC `LCTG_CYC(`LCTG_MRD_PS, `LCTG_MRD_NCK)

// Timer slots
`define LCTG_NT 7
`define LCTG_T_GEN 0
`define LCTG_T_MRR 1
`define LCTG_T_MRW 2
`define LCTG_T_CKE 3
`define LCTG_T_CMDPD 4
`define LCTG_T_MRRI 5
`define LCTG_T_HOLD 6

`endif

/* design/lctg_pkg.sv */
package lctg_pkg;

  typedef enum logic [3:0] {
    CMD_OTHER = 4'h0,
    CMD_WRITE = 4'h1,
    CMD_MRW = 4'h2,
    CMD_MRR = 4'h3,
    CMD_ZQ_START = 4'h4,
    CMD_ZQ_LATCH = 4'h5,
    CMD_ZQ_RESET = 4'h6,
    CMD_PD_ENTER = 4'h7,
    CMD_PD_EXIT = 4'h8
  } lctg_cmd_type;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h0,
    ST_WRITE = 3'h1,
    ST_HOLD = 3'h2,
    ST_PD = 3'h3,
    ST_WAKE = 3'h4
  } lctg_state_type;

  typedef struct packed {
    lctg_cmd_type cmd;
    logic [5:0] ca;
  } lctg_req_type;

  typedef struct packed {
    logic ck;
    logic cke;
    logic cs;
    logic [5:0] ca;
    logic dqs;
    logic dqs_oe;
  } lctg_pins_type;

endpackage

/* design/lctg_timer.sv */
`timescale 1ns/1ps
module lctg_timer (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic done
);
  logic [7:0] cnt_reg;

  // Loaded with N-1 so the next use is allowed N ticks later
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
    end else if (load) begin
      cnt_reg <= (load_val == 8'h00) ? 8'h00 : 8'(load_val - 8'h01);
    end else if (tick && cnt_reg != 8'h00) begin
      cnt_reg <= 8'(cnt_reg - 8'h01);
    end
  end

  assign done = (cnt_reg == 8'h00);
endmodule

/* design/lctg_guard.sv */
`timescale 1ns/1ps
`include "lctg_defines.svh"

// Behaviour
// [RULE1] First strobe latch edge 0.75 to 1.25 clocks after write latency
// [RULE2] Strobe preamble at least 2.0 clocks; postamble 0.5 or 1.5 as configured
// [RULE3] Wait max(30ns, 8 clocks) after calibration latch before next command
// [RULE4] Wait max(50ns, 3 clocks) after calibration reset before any command
// [RULE5] Each CKE high and low level lasts max(7.5ns, 4 clocks)
// [RULE6] Last valid command to CKE low at least max(1.75ns, 3 clocks)
// [RULE7] Clock keeps running max(5ns, 5 clocks) after CKE falls
// [RULE8] CS valid at least 1.75ns before CKE falls
// [RULE9] CS valid at least max(5ns, 5 clocks) after CKE falls
// [RULE10] Clock runs max(1.75ns, 3 clocks) before CKE rises
// [RULE11] No valid command until max(7.5ns, 5 clocks) after CKE rises
// [RULE12] CS valid at least 1.75ns before CKE rises
// [RULE13] CS valid at least max(7.5ns, 5 clocks) after CKE rises
// [RULE14] After mode write, clock and CS valid max(14ns, 10 clocks) past CKE fall
// [RULE15] After calibration start, clock and CS valid max(1.75ns, 3 clocks) past CKE fall
// [RULE16] Mode read waits row-to-column delay plus 3 clocks beyond exit delay
// [RULE17] Mode reads spaced at least 8 clocks
// [RULE18] Mode writes spaced at least max(10ns, 10 clocks)
// [RULE19] After mode set, wait max(14ns, 10 clocks) before next command
// [RULE20] Times round up to clocks, then take larger of time and cycle minimum
module lctg_guard
  import lctg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire lctg_req_type req,
  output logic req_ready,
  input wire logic pst_long,
  output lctg_pins_type pins
);
  lctg_state_type state_reg;
  lctg_cmd_type last_cmd_reg;
  logic phase_reg;
  logic ck_run_reg;
  logic ck_reg;
  logic cke_reg;
  logic cs_reg;
  logic [5:0] ca_reg;
  logic dqs_reg;
  logic dqs_oe_reg;
  logic ready_reg;
  logic [7:0] wr_half_reg;
  logic [7:0] wr_pos;
  logic [7:0] wr_end;
  logic tick;
  logic accept;
  logic cmd_slot;
  logic allow;
  logic [7:0] hold_cyc;
  logic [`LCTG_NT-1:0] t_load;
  logic [`LCTG_NT-1:0] t_done;
  logic [7:0] t_val [`LCTG_NT];

  // One tick per link clock, in the cycle where the link clock is high
  assign tick = phase_reg;
  assign accept = req_valid & ready_reg;
  assign cmd_slot = accept & (state_reg == ST_ACTIVE) & (req.cmd != CMD_PD_ENTER) &
                    (req.cmd != CMD_PD_EXIT);

  genvar gi;
  generate
    for (gi = 0; gi < `LCTG_NT; gi++) begin : g_timer
      lctg_timer u_timer (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .tick(tick),
        .load(t_load[gi]),
        .load_val(t_val[gi]),
        .done(t_done[gi])
      );
    end
  endgenerate

  // Clock stays valid long enough for whatever preceded power-down entry
  always_comb begin
    hold_cyc = 8'(`LCTG_CKELCK_CYC); // RULE7
    if (8'(`LCTG_CKELCS_CYC) > hold_cyc) begin
      hold_cyc = 8'(`LCTG_CKELCS_CYC); // RULE9
    end
    if (last_cmd_reg == CMD_MRW && 8'(`LCTG_MRWCKEL_CYC) > hold_cyc) begin
      hold_cyc = 8'(`LCTG_MRWCKEL_CYC); // RULE14
    end
    if (last_cmd_reg == CMD_ZQ_START && 8'(`LCTG_ZQCKE_CYC) > hold_cyc) begin
      hold_cyc = 8'(`LCTG_ZQCKE_CYC); // RULE15
    end
  end

  // Whether the waiting request may go at the coming tick
  always_comb begin
    allow = 1'b0;
    case (state_reg)
      ST_ACTIVE: begin
        case (req.cmd)
          CMD_PD_ENTER: begin
            allow = t_done[`LCTG_T_CMDPD] & t_done[`LCTG_T_CKE] & t_done[`LCTG_T_GEN]; // RULE6
          end
          CMD_PD_EXIT: begin
            allow = 1'b1;
          end
          CMD_MRR: begin
            allow = t_done[`LCTG_T_GEN] & t_done[`LCTG_T_MRR] & t_done[`LCTG_T_MRRI]; // RULE16
          end
          CMD_MRW: begin
            allow = t_done[`LCTG_T_GEN] & t_done[`LCTG_T_MRW]; // RULE18
          end
          default: begin
            allow = t_done[`LCTG_T_GEN]; // RULE11
          end
        endcase
      end
      ST_PD: begin
        allow = (req.cmd == CMD_PD_EXIT) & t_done[`LCTG_T_CKE]; // RULE5
      end
      default: begin
        allow = 1'b0;
      end
    endcase
  end

  // Timer loads
  always_comb begin
    t_load = '0;
    for (int i = 0; i < `LCTG_NT; i++) begin
      t_val[i] = 8'h00;
    end
    if (accept && state_reg == ST_ACTIVE && req.cmd != CMD_PD_EXIT) begin
      if (req.cmd == CMD_PD_ENTER) begin
        t_load[`LCTG_T_CKE] = 1'b1;
        t_val[`LCTG_T_CKE] = 8'(`LCTG_CKE_CYC); // RULE5
        t_load[`LCTG_T_HOLD] = 1'b1;
        t_val[`LCTG_T_HOLD] = hold_cyc; // RULE7
      end else begin
        t_load[`LCTG_T_CMDPD] = 1'b1;
        t_val[`LCTG_T_CMDPD] = 8'(`LCTG_CMDCKE_CYC); // RULE6
        t_load[`LCTG_T_GEN] = 1'b1;
        case (req.cmd)
          CMD_ZQ_LATCH: t_val[`LCTG_T_GEN] = 8'(`LCTG_ZQLAT_CYC); // RULE3
          CMD_ZQ_RESET: t_val[`LCTG_T_GEN] = 8'(`LCTG_ZQRESET_CYC); // RULE4
          CMD_MRW: t_val[`LCTG_T_GEN] = 8'(`LCTG_MRD_CYC); // RULE19
          default: t_val[`LCTG_T_GEN] = 8'h01;
        endcase
        if (req.cmd == CMD_MRR) begin
          t_load[`LCTG_T_MRR] = 1'b1;
          t_val[`LCTG_T_MRR] = 8'(`LCTG_MRR_NCK); // RULE17
        end
        if (req.cmd == CMD_MRW) begin
          t_load[`LCTG_T_MRW] = 1'b1;
          t_val[`LCTG_T_MRW] = 8'(`LCTG_MRW_CYC); // RULE18
        end
      end
    end else if (accept && state_reg == ST_PD) begin
      t_load[`LCTG_T_HOLD] = 1'b1;
      t_val[`LCTG_T_HOLD] = 8'(`LCTG_CKCKEH_CYC); // RULE10
    end else if (tick && state_reg == ST_WAKE && t_done[`LCTG_T_HOLD]) begin
      t_load[`LCTG_T_CKE] = 1'b1;
      t_val[`LCTG_T_CKE] = 8'(`LCTG_CKE_CYC); // RULE5
      t_load[`LCTG_T_GEN] = 1'b1;
      t_val[`LCTG_T_GEN] = 8'(`LCTG_XP_CYC); // RULE11
      t_load[`LCTG_T_MRRI] = 1'b1;
      t_val[`LCTG_T_MRRI] = 8'(`LCTG_MRRI_CYC); // RULE16
    end
  end

  // Free-running phase; link clock gated only while powered down
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_reg <= 1'b0;
    end else begin
      ck_reg <= ck_run_reg & ~phase_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_reg <= 1'b0;
    end else begin
      // Only a request already on the port is judged, never a stale command
      ready_reg <= ~phase_reg & req_valid & allow & ~ready_reg;
    end
  end

  // Write strobe position, one step per half link cycle
  assign wr_pos = 8'(wr_half_reg + 8'h01);
  // Postamble counts from the last falling edge, at the final burst position
  assign wr_end = pst_long ? 8'(`LCTG_BURST_LAST_HALF + `LCTG_PST_LONG_HALF) :
                  8'(`LCTG_BURST_LAST_HALF + `LCTG_PST_SHORT_HALF); // RULE2

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_ACTIVE;
      ck_run_reg <= 1'b1;
      cke_reg <= 1'b1;
      wr_half_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_ACTIVE: begin
          wr_half_reg <= 8'h00;
          if (accept && req.cmd == CMD_WRITE) begin
            state_reg <= ST_WRITE;
          end else if (accept && req.cmd == CMD_PD_ENTER) begin
            cke_reg <= 1'b0; // RULE8
            state_reg <= ST_HOLD;
          end
        end
        ST_WRITE: begin
          wr_half_reg <= wr_pos;
          if (wr_pos == wr_end) begin
            state_reg <= ST_ACTIVE;
          end
        end
        ST_HOLD: begin
          if (tick && t_done[`LCTG_T_HOLD]) begin
            ck_run_reg <= 1'b0; // RULE7
            state_reg <= ST_PD;
          end
        end
        ST_PD: begin
          if (accept) begin
            ck_run_reg <= 1'b1; // RULE10
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (tick && t_done[`LCTG_T_HOLD]) begin
            cke_reg <= 1'b1; // RULE12
            state_reg <= ST_ACTIVE;
          end
        end
        default: begin
          state_reg <= ST_ACTIVE;
        end
      endcase
    end
  end

  // Command pins: CS high for one link clock, low (valid deselect) otherwise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_reg <= 1'b0;
    end else if (tick && cmd_slot) begin
      cs_reg <= 1'b1;
    end else if (tick) begin
      cs_reg <= 1'b0; // RULE13
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ca_reg <= 6'h00;
    end else if (tick && cmd_slot) begin
      ca_reg <= req.ca;
    end else if (tick) begin
      ca_reg <= 6'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_cmd_reg <= CMD_OTHER;
    end else if (tick && cmd_slot) begin
      last_cmd_reg <= req.cmd;
    end
  end

  // Strobe enable: driven low for the preamble, through the burst and the postamble
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqs_oe_reg <= 1'b0;
    end else if (state_reg == ST_WRITE && wr_pos != wr_end) begin
      dqs_oe_reg <= (wr_pos >= 8'(`LCTG_PRE_START_HALF)); // RULE2
    end else begin
      dqs_oe_reg <= 1'b0;
    end
  end

  // Latch position is odd, so odd positions give the rising edges of the burst
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqs_reg <= 1'b0;
    end else if (state_reg == ST_WRITE && wr_pos >= 8'(`LCTG_LATCH_HALF) &&
                 wr_pos < 8'(`LCTG_BURST_END_HALF)) begin
      dqs_reg <= wr_pos[0]; // RULE1
    end else begin
      dqs_reg <= 1'b0;
    end
  end

  assign req_ready = ready_reg;
  assign pins = '{ck: ck_reg, cke: cke_reg, cs: cs_reg, ca: ca_reg,
                  dqs: dqs_reg, dqs_oe: dqs_oe_reg}; // RULE20
endmodule

/* tb/lctg_guard_monitor.sv */
`timescale 1ns/1ps
module lctg_guard_monitor
  import lctg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire lctg_req_type req,
  input wire logic req_ready,
  input wire logic pst_long,
  input wire lctg_pins_type pins
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic acc;
  logic [7:0] gap_reg [16];
  logic [7:0] idle_reg;
  logic [7:0] tog_reg;
  logic [7:0] wake_reg;
  logic ck_reg;
  logic cke_reg;
  lctg_cmd_type last_reg;
  assign acc = req_valid & req_ready;
  function automatic logic [7:0] sat(input logic [7:0] x);
    return (x == 8'hff) ? x : x + 8'h01;
  endfunction
  // Cycles since each command kind, since select, clock run length, since wake
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++)
        gap_reg[i] <= 8'hff;
      idle_reg <= 8'hff;
      tog_reg <= 8'h00;
      wake_reg <= 8'hff;
      ck_reg <= 1'b0;
      cke_reg <= 1'b1;
      last_reg <= CMD_OTHER;
    end else begin
      for (int i = 0; i < 16; i++)
        gap_reg[i] <= (acc && req.cmd == i[3:0]) ? 8'h00 : sat(gap_reg[i]);
      idle_reg <= pins.cs ? 8'h00 : sat(idle_reg);
      tog_reg <= (pins.ck != ck_reg) ? sat(tog_reg) : 8'h00;
      wake_reg <= (pins.cke && !cke_reg) ? 8'h00 : sat(wake_reg);
      ck_reg <= pins.ck;
      cke_reg <= pins.cke;
      if (acc && req.cmd != CMD_PD_ENTER && req.cmd != CMD_PD_EXIT)
        last_reg <= req.cmd;
    end
  end
  first_latch_a: assert property ($rose(pins.cs) && last_reg == CMD_WRITE
    |-> ##15 $rose(pins.dqs)) else $error("first latch edge misplaced");
  pre_len_a: assert property ($rose(pins.dqs_oe) |-> !pins.dqs [*4] ##1 pins.dqs)
    else $error("preamble length wrong");
  post_len_a: assert property ($fell(pins.dqs_oe) |-> pst_long ?
    ($past(pins.dqs, 4) && !$past(pins.dqs, 3)) : ($past(pins.dqs, 2) && !$past(pins.dqs, 1)))
    else $error("postamble length wrong");
  latch_gap_a: assert property (acc |-> gap_reg[CMD_ZQ_LATCH] >= 8'd15)
    else $error("command too soon after latch");
  zrst_gap_a: assert property (acc |-> gap_reg[CMD_ZQ_RESET] >= 8'd5)
    else $error("command too soon after reset");
  cke_pulse_a: assert property ($changed(pins.cke) |=> $stable(pins.cke) [*7])
    else $error("clock enable pulse short");
  cmd_pd_a: assert property ($fell(pins.cke) |-> idle_reg >= 8'd4)
    else $error("power-down too soon after command");
  pd_hold_a: assert property ($fell(pins.cke) |->
    ($changed(pins.ck) && !pins.cs) [*8] ##1 ($changed(pins.ck) && !pins.cs) [*2])
    else $error("clock or select invalid after entry");
  mrw_hold_a: assert property ($fell(pins.cke) && last_reg == CMD_MRW |->
    $changed(pins.ck) [*8] ##1 $changed(pins.ck) [*8] ##1 $changed(pins.ck) [*4])
    else $error("clock stopped early after mode write");
  wake_ck_a: assert property ($rose(pins.cke) |-> tog_reg >= 8'd5)
    else $error("clock not running before wake");
  wake_cs_a: assert property ($rose(pins.cke) |-> !pins.cs [*8] ##1 !pins.cs [*2])
    else $error("select active too soon after wake");
  mrr_wake_a: assert property (acc && req.cmd == CMD_MRR |-> wake_reg >= 8'd22)
    else $error("mode read too soon after wake");
  mrr_gap_a: assert property (acc && req.cmd == CMD_MRR |-> gap_reg[CMD_MRR] >= 8'd15)
    else $error("mode reads too close");
  mrw_gap_a: assert property (acc |-> gap_reg[CMD_MRW] >= 8'd19)
    else $error("command too soon after mode write");
endmodule

bind lctg_guard lctg_guard_monitor mon (.ref_clk(ref_clk), .arst_n(arst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .pst_long(pst_long), .pins(pins));

/* tb/lctg_sdram_model.sv */
`timescale 1ns/1ps
module lctg_sdram_model
  import lctg_pkg::*;
(
  input wire lctg_pins_type pins,
  output int cmd_cnt,
  output logic [5:0] last_ca
);
  initial cmd_cnt = 0;
  initial last_ca = 6'h00;
  // Command latched on rising clock while selected and enabled
  always @(posedge pins.ck) begin
    if (pins.cke && pins.cs) begin
      cmd_cnt <= cmd_cnt + 1;
      last_ca <= pins.ca;
    end
  end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import lctg_pkg::*;
  logic ref_clk;
  logic arst_n;
  logic req_valid;
  lctg_req_type req;
  logic req_ready;
  logic pst_long;
  lctg_pins_type pins;
  int cmd_cnt;
  logic [5:0] last_ca;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_acc;
  lctg_guard dut (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .pst_long(pst_long), .pins(pins));
  lctg_sdram_model mem (.pins(pins), .cmd_cnt(cmd_cnt), .last_ca(last_ca));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Held until ready seen, released at the following falling edge
  task automatic issue(input lctg_cmd_type c, input logic [5:0] a);
    int n;
    n = 0;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req = '{cmd: c, ca: a};
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    t_acc = cyc;
    chk("ready_wait", n < 300, 1);
  endtask
  task automatic pair(input lctg_cmd_type a, input lctg_cmd_type b, output int gap);
    int t0;
    issue(a, 6'h2a);
    t0 = t_acc;
    issue(b, 6'h15);
    gap = t_acc - t0;
  endtask
  task automatic t_space();
    int g;
    int n0;
    n0 = cmd_cnt;
    pair(CMD_MRW, CMD_MRW, g);
    chk("mrw_gap", g >= 20, 1);
    pair(CMD_MRW, CMD_OTHER, g);
    chk("mrd_gap", g >= 20, 1);
    pair(CMD_MRR, CMD_MRR, g);
    chk("mrr_gap", g >= 16, 1);
    pair(CMD_ZQ_LATCH, CMD_OTHER, g);
    chk("latch_gap", g >= 16, 1);
    pair(CMD_ZQ_RESET, CMD_OTHER, g);
    chk("zrst_gap", g >= 6, 1);
    pair(CMD_ZQ_START, CMD_OTHER, g);
    issue(CMD_PD_EXIT, 6'h00);
    repeat (4) @(negedge ref_clk);
    chk("ca_out", last_ca, 6'h15);
    chk("cmd_cnt", cmd_cnt - n0, 12);
    chk("cke_on", pins.cke, 1'b1);
    $display("test spacing done");
  endtask
  task automatic t_write(input logic lng);
    int f_oe;
    int f_dq;
    int l_hi;
    int e_oe;
    f_oe = 0;
    f_dq = 0;
    l_hi = 0;
    e_oe = 0;
    pst_long = lng;
    issue(CMD_WRITE, 6'h07);
    for (int i = 1; i < 45; i++) begin
      if (pins.dqs_oe === 1'b1 && f_oe == 0)
        f_oe = i;
      if (pins.dqs === 1'b1 && f_dq == 0)
        f_dq = i;
      if (pins.dqs === 1'b1)
        l_hi = i;
      if (pins.dqs_oe !== 1'b1 && f_oe != 0 && e_oe == 0)
        e_oe = i;
      @(negedge ref_clk);
    end
    chk("first_latch", f_dq, 16);
    chk("preamble", f_dq - f_oe, 4);
    chk("postamble", e_oe - l_hi, lng ? 4 : 2);
    $display("test write done");
  endtask
  task automatic t_pd(input lctg_cmd_type pre, input int exp);
    int t0;
    int tg;
    int tf;
    logic ckp;
    issue(pre, 6'h11);
    t0 = t_acc;
    issue(CMD_PD_ENTER, 6'h00);
    chk("cmd_to_pd", t_acc - t0 >= 6, 1);
    tf = t_acc;
    tg = 0;
    ckp = pins.ck;
    repeat (30) begin
      @(negedge ref_clk);
      if (pins.ck !== ckp)
        tg++;
      ckp = pins.ck;
    end
    chk("ck_hold", tg, exp);
    chk("ck_stop", pins.ck, 1'b0);
    issue(CMD_PD_EXIT, 6'h00);
    tg = 0;
    for (int i = 0; i < 40 && pins.cke !== 1'b1; i++) begin
      ckp = pins.ck;
      @(negedge ref_clk);
      tg = (pins.ck !== ckp) ? tg + 1 : 0;
    end
    chk("cke_low", cyc - tf >= 8, 1);
    chk("ck_pre_wake", tg >= 6, 1);
    t0 = cyc;
    issue(CMD_MRR, 6'h21);
    chk("wake_to_mrr", t_acc - t0 >= 22, 1);
    $display("test power-down done");
  endtask
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    pst_long = 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    t_space();
    t_write(1'b0);
    t_write(1'b1);
    t_pd(CMD_OTHER, 10);
    t_pd(CMD_MRW, 20);
    t_pd(CMD_ZQ_START, 10);
    summarize();
  end
endmodule
